/* File: src/lcr_router.sv */
// Configuration registers and master port routing for a second-level cache.
// Assumes one clock, an APB master driving the registers, and upstream logic
// presenting one classified request per cycle with valid/ready handshake.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps

module lcr_router
  import lcr_pkg::*;
#(
  parameter bit SECOND_SLAVE_OPTION     = 1'b0,
  parameter bit SECOND_MASTER_OPTION    = 1'b0,
  parameter bit RANGE_FILTER_OPTION     = 1'b0,
  parameter bit SIXTEEN_WAY_OPTION      = 1'b0,
  parameter bit DATA_RAM_BANKING_OPTION = 1'b0,
  parameter bit PARITY_OPTION           = 1'b0,
  parameter bit LOCK_BY_REQUESTER_OPTION = 1'b0,
  parameter bit LOCK_BY_LINE_OPTION     = 1'b0,
  parameter bit SPECULATIVE_READ_OPTION = 1'b0,
  parameter bit MASTER_SIDEBAND_OPTION  = 1'b0,
  parameter int SLAVE_ID_WIDTH_PARAM    = LCR_ID_W_DEF,
  parameter int ADDR_W                  = 32
) (
  // Clock, reset, enable.
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   clk_en_in,
  // APB slave.
  input  wire logic                   psel_in,
  input  wire logic                   penable_in,
  input  wire logic                   pwrite_in,
  input  wire logic [11:0]            paddr_in,
  input  wire logic [31:0]            pwdata_in,
  output logic      [31:0]            prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // Configuration pins, from outside the clock domain.
  input  wire logic [2:0]             way_size_select_in,
  input  wire logic                   associativity_in,
  // Request stream.
  input  wire logic                   req_valid_in,
  output logic                        req_ready_out,
  input  wire logic [2:0]             req_class_in,
  input  wire logic [1:0]             req_src_in,
  input  wire logic [ADDR_W-1:0]      req_addr_in,
  input  wire logic [SLAVE_ID_WIDTH_PARAM:0] req_id_in,
  // Master port zero.
  output logic                        mst0_valid_out,
  input  wire logic                   mst0_ready_in,
  output logic [ADDR_W-1:0]           mst0_addr_out,
  output logic [SLAVE_ID_WIDTH_PARAM+2:0] mst0_id_out,
  output logic [2:0]                  mst0_class_out,
  // Master port one.
  output logic                        mst1_valid_out,
  input  wire logic                   mst1_ready_in,
  output logic [ADDR_W-1:0]           mst1_addr_out,
  output logic [SLAVE_ID_WIDTH_PARAM+2:0] mst1_id_out,
  output logic [2:0]                  mst1_class_out,
  // Effective configuration.
  output logic [2:0]                  way_size_out,
  output logic                        sixteen_way_out,
  output logic [2:0]                  ram_latency_out
);

  localparam int SID_W = SLAVE_ID_WIDTH_PARAM + 1;
  localparam int MID_W = SLAVE_ID_WIDTH_PARAM + 3;
  localparam int ENT_W = ADDR_W + SID_W + 3 + 2;

  // Illegal option sets are narrowed to the nearest legal build, so that a
  // second master never exists without a second slave, nor a filter
  // without a second master.
  localparam bit M1_ON  = SECOND_MASTER_OPTION && SECOND_SLAVE_OPTION;
  localparam bit FLT_ON = RANGE_FILTER_OPTION && M1_ON;

  // Registers.
  logic              flt_en;
  logic [2:0]        way_reg;
  logic              assoc_reg;
  logic              use_reg;
  logic [2:0]        lat_reg;
  logic [ADDR_W-1:0] flt_base;
  logic [ADDR_W-1:0] flt_mask;
  logic [2:0]        way_s1, way_s2;
  logic              asc_s1, asc_s2;
  logic [31:0]       next_rdata;
  logic              addr_ok;
  logic [1:0]        cnt;

  wire apb_acc = psel_in && penable_in && clk_en_in;
  wire apb_wr  = apb_acc && pwrite_in && addr_ok;

  // Pin synchronisers.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      way_s1 <= LCR_WAY_RST;
      way_s2 <= LCR_WAY_RST;
      asc_s1 <= LCR_ASSOC_RST;
      asc_s2 <= LCR_ASSOC_RST;
    end else if (clk_en_in) begin
      way_s1 <= way_size_select_in;
      way_s2 <= way_s1;
      asc_s1 <= associativity_in;
      asc_s2 <= asc_s1;
    end
  end

  // Software-written configuration.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flt_en    <= 1'b0;
      way_reg   <= LCR_WAY_RST;
      assoc_reg <= LCR_ASSOC_RST;
      use_reg   <= 1'b0;
      lat_reg   <= LCR_LAT_RST;
      flt_base  <= '0;
      flt_mask  <= '0;
    end else if (apb_wr) begin
      unique case (paddr_in)
        LCR_OFF_CTRL: flt_en <= pwdata_in[LCR_CTRL_FLT_EN] && FLT_ON;
        LCR_OFF_AUX: begin
          way_reg   <= pwdata_in[LCR_AUX_WAY_LO +: 3];
          assoc_reg <= pwdata_in[LCR_AUX_ASSOC];
          use_reg   <= pwdata_in[LCR_AUX_USE_REG];
        end
        LCR_OFF_LAT:      lat_reg  <= pwdata_in[2:0];
        LCR_OFF_FLT_BASE: flt_base <= pwdata_in[ADDR_W-1:0];
        LCR_OFF_FLT_MASK: flt_mask <= pwdata_in[ADDR_W-1:0];
        default: ;
      endcase
    end
  end

  // Effective configuration outputs.
  logic [2:0] way_pick;
  logic       asc_pick;
  always_comb begin
    way_pick = use_reg ? way_reg : way_s2;
    asc_pick = use_reg ? assoc_reg : asc_s2;
    // Codes outside 16KB..512KB clamp to the nearest legal size.
    if (way_pick == 3'h0) way_pick = 3'h1;
    if (way_pick == 3'h7) way_pick = 3'h6;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      way_size_out    <= LCR_WAY_RST;
      sixteen_way_out <= LCR_ASSOC_RST;
      ram_latency_out <= LCR_LAT_RST;
    end else if (clk_en_in) begin
      way_size_out    <= way_pick;
      sixteen_way_out <= asc_pick && SIXTEEN_WAY_OPTION;
      ram_latency_out <= lat_reg;
    end
  end

  // Read mux; status shows buffer occupancy, effective way size and sixteen-way mode, build shows the options.
  always_comb begin
    addr_ok    = 1'b1;
    next_rdata = 32'h0;
    unique case (paddr_in)
      LCR_OFF_CTRL:     next_rdata[0] = flt_en;
      LCR_OFF_AUX:      next_rdata[4:0] = {use_reg, assoc_reg, way_reg};
      LCR_OFF_LAT:      next_rdata[2:0] = lat_reg;
      LCR_OFF_FLT_BASE: next_rdata[ADDR_W-1:0] = flt_base;
      LCR_OFF_FLT_MASK: next_rdata[ADDR_W-1:0] = flt_mask;
      LCR_OFF_STATUS:   next_rdata[5:0] = {sixteen_way_out, way_size_out,
                                           cnt};
      LCR_OFF_BUILD:    next_rdata[9:0] = {MASTER_SIDEBAND_OPTION,
                                           SPECULATIVE_READ_OPTION,
                                           LOCK_BY_LINE_OPTION,
                                           LOCK_BY_REQUESTER_OPTION,
                                           PARITY_OPTION,
                                           DATA_RAM_BANKING_OPTION,
                                           SIXTEEN_WAY_OPTION,
                                           RANGE_FILTER_OPTION,
                                           SECOND_MASTER_OPTION,
                                           SECOND_SLAVE_OPTION};
      default:          addr_ok = 1'b0;
    endcase
  end

  // Zero-wait APB answer registered in the setup cycle.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_out  <= 32'h0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else if (clk_en_in) begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !addr_ok;
      prdata_out  <= next_rdata;
    end
  end

  // Two-entry request buffer: a stalled master port loses no request.
  logic [ENT_W-1:0] buf_mem [2];
  logic             wr_ptr, rd_ptr;
  wire              in_fire = req_valid_in && req_ready_out && clk_en_in;
  logic             out_fire;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      cnt    <= 2'h0;
    end else begin
      if (in_fire) begin
        buf_mem[wr_ptr] <= {req_class_in, req_src_in, req_addr_in,
                            req_id_in};
        wr_ptr <= ~wr_ptr;
      end
      if (out_fire) rd_ptr <= ~rd_ptr;
      cnt <= cnt + 2'(in_fire) - 2'(out_fire);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) req_ready_out <= 1'b1;
    else req_ready_out <= (cnt + 2'(in_fire) - 2'(out_fire)) != 2'h2;
  end

  // Route decision for the head entry.
  logic [2:0]        h_cls;
  logic [1:0]        h_src;
  logic [ADDR_W-1:0] h_addr;
  logic [SID_W-1:0]  h_id;
  logic              in_range, to_one, rr;
  assign {h_cls, h_src, h_addr, h_id} = buf_mem[rd_ptr];

  always_comb begin
    in_range = ((h_addr ^ flt_base) & flt_mask) == '0;
    to_one   = 1'b0;
    if (!M1_ON) begin
      to_one = 1'b0;
    end else if (flt_en) begin
      to_one = in_range;
    end else begin
      unique case (h_cls)
        LCR_UNCACHED_READ: to_one = (h_src == LCR_SRC_SLAVE1);
        LCR_UNBUF_WRITE:   to_one = (h_src == LCR_SRC_SLAVE1);
        LCR_LINEFILL,
        LCR_ALLOC_READ:    to_one = rr;
        LCR_BUF_WRITE,
        LCR_EVICTION:      to_one = rr;
        default:           to_one = 1'b0;
      endcase
    end
  end

  // Output stage: one registered slot per master port.
  wire head_ok = cnt != 2'h0;
  wire slot_free = to_one ? (!mst1_valid_out || mst1_ready_in)
                          : (!mst0_valid_out || mst0_ready_in);
  assign out_fire = head_ok && slot_free && clk_en_in;

  // Master IDs gain two bits naming the source.
  wire [MID_W-1:0] h_mid = {h_src, h_id};

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mst0_valid_out <= 1'b0;
      mst0_addr_out  <= '0;
      mst0_id_out    <= '0;
      mst0_class_out <= 3'h0;
      mst1_valid_out <= 1'b0;
      mst1_addr_out  <= '0;
      mst1_id_out    <= '0;
      mst1_class_out <= 3'h0;
      rr             <= 1'b0;
    end else if (clk_en_in) begin
      if (mst0_ready_in) mst0_valid_out <= 1'b0;
      if (mst1_ready_in || !M1_ON) mst1_valid_out <= 1'b0;
      if (out_fire) begin
        if (to_one) begin
          mst1_valid_out <= 1'b1;
          mst1_addr_out  <= h_addr;
          mst1_id_out    <= h_mid;
          mst1_class_out <= h_cls;
        end else begin
          mst0_valid_out <= 1'b1;
          mst0_addr_out  <= h_addr;
          mst0_id_out    <= h_mid;
          mst0_class_out <= h_cls;
        end
        if (h_cls >= LCR_LINEFILL) rr <= ~rr;
      end
    end
  end

endmodule : lcr_router

/* File: src/lcr_pkg.sv */
// Constants, register map and traffic-class encodings for the cache port
// configuration and routing block.
// Assumes a single clock domain and an APB register bus with 32-bit data.

package lcr_pkg;

  localparam int LCR_DATA_W = 64;

  // Register byte offsets.
  localparam logic [11:0] LCR_OFF_CTRL     = 12'h000;
  localparam logic [11:0] LCR_OFF_AUX      = 12'h004;
  localparam logic [11:0] LCR_OFF_LAT      = 12'h008;
  localparam logic [11:0] LCR_OFF_FLT_BASE = 12'h00c;
  localparam logic [11:0] LCR_OFF_FLT_MASK = 12'h010;
  localparam logic [11:0] LCR_OFF_STATUS   = 12'h014;
  localparam logic [11:0] LCR_OFF_BUILD    = 12'h018;

  // Field positions.
  localparam int LCR_CTRL_FLT_EN   = 0;
  localparam int LCR_AUX_WAY_LO    = 0;
  localparam int LCR_AUX_ASSOC     = 3;
  localparam int LCR_AUX_USE_REG   = 4;

  // Reset values.
  localparam logic [2:0] LCR_WAY_RST   = 3'h1;
  localparam logic       LCR_ASSOC_RST = 1'b0;
  localparam logic [2:0] LCR_LAT_RST   = 3'h7;
  localparam int         LCR_ID_W_DEF  = 5;

  // Traffic classes arriving at the router.
  typedef enum logic [2:0] {
    LCR_UNCACHED_READ,
    LCR_UNBUF_WRITE,
    LCR_LINEFILL,
    LCR_ALLOC_READ,
    LCR_BUF_WRITE,
    LCR_EVICTION
  } lcr_class_e;

  // Source of a request.
  typedef enum logic [1:0] {
    LCR_SRC_SLAVE0,
    LCR_SRC_SLAVE1,
    LCR_SRC_WBUF,
    LCR_SRC_VICTIM
  } lcr_src_e;

endpackage : lcr_pkg

/* File: sim/lcr_router_asserts.sv */
// Concurrent checks on the ports of the cache port routing block.
// Assumes one clock and that it is bound into every lcr_router instance.
`timescale 1ns/1ps
module lcr_router_chk
  import lcr_pkg::*;
#(
  parameter int SLAVE_ID_WIDTH_PARAM = LCR_ID_W_DEF,
  parameter int ADDR_W               = 32
) (
  // Clock, reset and APB.
  input wire logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out, pslverr_out,
  // Master ports.
  input wire logic mst0_valid_out, mst0_ready_in,
  input wire logic mst1_valid_out, mst1_ready_in,
  input wire logic [ADDR_W-1:0] mst0_addr_out, mst1_addr_out,
  input wire logic [SLAVE_ID_WIDTH_PARAM+2:0] mst0_id_out, mst1_id_out,
  input wire logic [2:0] mst0_class_out, mst1_class_out,
  // Effective configuration.
  input wire logic [2:0] way_size_out, ram_latency_out
);
  localparam int T = SLAVE_ID_WIDTH_PARAM + 2;
  logic       flt_en;
  logic       lat_hit;
  logic [2:0] lat_q;
  wire logic  wfire = psel_in & penable_in & pready_out & pwrite_in;

  // Shadows of the filter enable and latency code, to judge the outputs.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      flt_en  <= 1'b0;
      lat_hit <= 1'b0;
      lat_q   <= LCR_LAT_RST;
    end else begin
      lat_hit <= wfire && paddr_in == LCR_OFF_LAT;
      if (wfire && paddr_in == LCR_OFF_LAT) lat_q <= pwdata_in[2:0];
      if (wfire && paddr_in == LCR_OFF_CTRL) flt_en <= pwdata_in[0];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  rst_values_a: assert property ($past(sys_rst_in) |->
    way_size_out == LCR_WAY_RST && ram_latency_out == LCR_LAT_RST &&
    !mst0_valid_out && !mst1_valid_out) else $error("bad reset values");
  apb_wait_a: assert property (psel_in && penable_in |-> pready_out)
    else $error("access cycle without ready");
  apb_pulse_a: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access cycle");
  bad_addr_a: assert property (psel_in && penable_in &&
    paddr_in > LCR_OFF_BUILD |-> pslverr_out) else $error("no slave error");
  hold_zero_a: assert property (mst0_valid_out && !mst0_ready_in |=>
    mst0_valid_out && $stable(mst0_addr_out) && $stable(mst0_id_out))
    else $error("port zero request dropped");
  hold_one_a: assert property (mst1_valid_out && !mst1_ready_in |=>
    mst1_valid_out && $stable(mst1_addr_out) && $stable(mst1_class_out))
    else $error("port one request dropped");
  route_zero_a: assert property (mst0_valid_out && mst0_class_out < 3'h2
    && !flt_en |-> mst0_id_out[T-:2] == 2'h0) else $error("wrong port zero");
  route_one_a: assert property (mst1_valid_out && mst1_class_out < 3'h2
    && !flt_en |-> mst1_id_out[T-:2] == 2'h1) else $error("wrong port one");
  lat_follow_a: assert property (lat_hit |-> ##[0:3]
    ram_latency_out == lat_q) else $error("latency code not applied");

  cover property (mst1_valid_out && mst1_ready_in);
  cover property (mst0_valid_out && !mst0_ready_in ##1 mst0_valid_out);
  cover property (pslverr_out);
endmodule : lcr_router_chk

bind lcr_router lcr_router_chk #(.SLAVE_ID_WIDTH_PARAM(SLAVE_ID_WIDTH_PARAM),
  .ADDR_W(ADDR_W)) i_lcr_router_chk (.*);

/* File: sim/lcr_src_model.sv */
// Request source standing in for the processor-side request stream.
// Assumes send is entered just after a rising clock edge.
`timescale 1ns/1ps
module lcr_src_model (
  // Clock and handshake.
  input  wire logic  clk_in,
  input  wire logic  req_ready_in,
  // Request.
  output logic       req_valid_out = 1'b0,
  output logic [2:0] req_class_out = 3'h0,
  output logic [1:0] req_src_out   = 2'h0,
  output logic [31:0] req_addr_out = 32'h0,
  output logic [5:0] req_id_out    = 6'h0
);
  task automatic send(input logic [2:0] c, input logic [1:0] s,
                      input logic [31:0] a);
    req_valid_out <= 1'b1;
    req_class_out <= c;
    req_src_out   <= s;
    req_addr_out  <= a;
    req_id_out    <= 6'h2a;
    do @(posedge clk_in); while (req_ready_in !== 1'b1);
  endtask : send

  // Released address and ID fields are inverted so a stale value can never pass as valid.
  task automatic idle();
    req_valid_out <= 1'b0;
    req_addr_out  <= ~req_addr_out;
    req_id_out    <= ~req_id_out;
  endtask : idle
endmodule : lcr_src_model

/* File: sim/tb_lcr_router.sv */
// Self-checking bench for the cache port routing block.
// Assumes the router, its checker and the request source model are built.
`timescale 1ns/1ps
module tb_lcr_router;
  import lcr_pkg::*;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic        mst0_ready_in = 1'b1, mst1_ready_in = 1'b1;
  logic        associativity_in = 1'b0, pready_out, pslverr_out;
  logic        req_valid_in, req_ready_out, sixteen_way_out;
  logic        mst0_valid_out, mst1_valid_out;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, req_addr_in;
  logic [31:0] mst0_addr_out, mst1_addr_out;
  logic [2:0]  way_size_select_in = 3'h1, way_size_out, ram_latency_out;
  logic [2:0]  req_class_in, mst0_class_out, mst1_class_out;
  logic [1:0]  req_src_in;
  logic [5:0]  req_id_in;
  logic [7:0]  mst0_id_out, mst1_id_out;
  logic [42:0] q0[$], q1[$];
  int          fail_count = 0, compares = 0, cyc = 0;

  always #5 clk_in = ~clk_in;

  lcr_router #(.SECOND_SLAVE_OPTION(1'b1), .SECOND_MASTER_OPTION(1'b1),
    .RANGE_FILTER_OPTION(1'b1), .SIXTEEN_WAY_OPTION(1'b1)) i_lcr_router (.*);
  lcr_src_model i_lcr_src_model (.clk_in(clk_in),
    .req_ready_in(req_ready_out), .req_valid_out(req_valid_in),
    .req_class_out(req_class_in), .req_src_out(req_src_in),
    .req_addr_out(req_addr_in), .req_id_out(req_id_in));

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (mst0_valid_out && mst0_ready_in)
      q0.push_back({mst0_class_out, mst0_id_out, mst0_addr_out});
    if (mst1_valid_out && mst1_ready_in)
      q1.push_back({mst1_class_out, mst1_id_out, mst1_addr_out});
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask : wr

  // Waits for one beat on a master port; port 2 accepts either port.
  task automatic expect_out(input int p, input logic [2:0] c,
                            input logic [1:0] s, input logic [31:0] a);
    int          n;
    int          pt;
    logic [42:0] g;
    n = 0;
    while (q0.size() == 0 && q1.size() == 0 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    pt = (q0.size() != 0) ? 0 : 1;
    if (pt == 0) g = q0.pop_front();
    else if (q1.size() != 0) g = q1.pop_front();
    else g = 'x;
    if (p != 2) check(pt, p);
    check(g, {c, s, 6'h2a, a});
  endtask : expect_out

  task automatic one(input int p, input logic [2:0] c, input logic [1:0] s,
                     input logic [31:0] a);
    i_lcr_src_model.send(c, s, a);
    i_lcr_src_model.idle();
    expect_out(p, c, s, a);
  endtask : one

  task automatic t_regs();
    logic [31:0] rd;
    logic        er;
    wr(LCR_OFF_AUX, 32'h1d);
    repeat (4) @(posedge clk_in);
    check({sixteen_way_out, way_size_out}, 4'hd);
    apb(1'b0, LCR_OFF_AUX, 32'h0, rd, er);
    check(rd[4:0], 5'h1d);
    wr(LCR_OFF_LAT, 32'h2);
    repeat (4) @(posedge clk_in);
    check(ram_latency_out, 3'h2);
    apb(1'b0, 12'h020, 32'h0, rd, er);
    check(er, 1'b1);
    apb(1'b0, LCR_OFF_BUILD, 32'h0, rd, er);
    check(rd, 32'hf);
    wr(LCR_OFF_AUX, 32'h0);
    way_size_select_in <= 3'h6;
    associativity_in   <= 1'b1;
    repeat (6) @(posedge clk_in);
    check({sixteen_way_out, way_size_out}, 4'he);
  endtask : t_regs

  task automatic t_route();
    logic [7:0] fs;
    fs = 8'he8;
    for (int k = 0; k < 4; k++)
      one(k % 2, 3'(k / 2), 2'(k % 2), 32'h40 * k);
    for (int k = 2; k < 6; k++)
      one(2, 3'(k), fs[2*k-4 +: 2], 32'h1000 + k);
  endtask : t_route

  task automatic t_filter();
    wr(LCR_OFF_FLT_BASE, 32'h8000_0000);
    wr(LCR_OFF_FLT_MASK, 32'hf000_0000);
    wr(LCR_OFF_CTRL, 32'h1);
    one(1, LCR_UNCACHED_READ, LCR_SRC_SLAVE0, 32'h8000_0040);
    one(0, LCR_UNBUF_WRITE, LCR_SRC_SLAVE1, 32'h1000_0000);
    one(1, LCR_EVICTION, LCR_SRC_VICTIM, 32'h8fff_ffe0);
    one(0, LCR_BUF_WRITE, LCR_SRC_WBUF, 32'h7fff_ffe0);
    wr(LCR_OFF_CTRL, 32'h0);
  endtask : t_filter

  task automatic t_stall();
    mst0_ready_in <= 1'b0;
    fork
      begin
        for (int k = 0; k < 4; k++)
          i_lcr_src_model.send(3'h0, 2'h0, 32'h100 + k);
        i_lcr_src_model.idle();
      end
    join_none
    repeat (10) @(posedge clk_in);
    check(req_ready_out, 1'b0);
    mst0_ready_in <= 1'b1;
    for (int k = 0; k < 4; k++)
      expect_out(0, 3'h0, 2'h0, 32'h100 + k);
  endtask : t_stall

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    check({way_size_out, ram_latency_out}, 6'h0f);
    check({sixteen_way_out, req_ready_out}, 2'h1);
    check($bits(mst0_id_out), 8);
    t_regs();
    t_route();
    t_filter();
    t_stall();
    wrap_up();
  end
endmodule : tb_lcr_router
